// ### bench/ees_checker.sv
// Port assertions for the event sequencer, trigger and trace block.
// Assumes it is bound to ees_top and sees its single clock domain.
`timescale 1ns/1ps
module ees_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Watched ports.
  input wire ees_pkg::ees_bus_t tgt_bus,
  input wire logic prog_run,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [3:0] external_probe_connector_two,
  input wire logic break_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  property p_wait_one; !waitrequest |=> waitrequest; endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low too long");
  property p_wait_ans; (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("no answer after one cycle");
  property p_stop_probe;
    !prog_run |=> external_probe_connector_two == 4'h0;
  endproperty
  a_stop_probe: assert property (p_stop_probe)
    else $error("probe high while stopped");
  property p_probe_idle;
    !tgt_bus.valid |=> external_probe_connector_two == 4'h0;
  endproperty
  a_probe_idle: assert property (p_probe_idle)
    else $error("probe high without bus cycle");
  property p_run_start; $rose(prog_run) |-> !break_req; endproperty
  a_run_start: assert property (p_run_start)
    else $error("break pending at run start");
  property p_brk_hold; break_req && prog_run |=> break_req; endproperty
  a_brk_hold: assert property (p_brk_hold)
    else $error("break dropped during run");
  property p_brk_stop; !prog_run |=> !break_req; endproperty
  a_brk_stop: assert property (p_brk_stop)
    else $error("break held after stop");
  property p_brk_run; $rose(break_req) |-> $past(prog_run); endproperty
  a_brk_run: assert property (p_brk_run)
    else $error("break raised while stopped");
endmodule
bind ees_top ees_checker u_chk (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .tgt_bus(tgt_bus),
  .prog_run(prog_run),
  .read(read),
  .write(write),
  .waitrequest(waitrequest),
  .external_probe_connector_two(external_probe_connector_two),
  .break_req(break_req)
);

// ### bench/ees_tgt_model.sv
// Target bus model: single bus cycles and the run level.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
module ees_tgt_model (
  // Clock.
  input wire logic sys_clk,
  // Target side.
  output ees_pkg::ees_bus_t tgt_bus,
  output logic prog_run
);
  initial begin
    tgt_bus = '0;
    prog_run = 1'h0;
  end
  // An idle bus shows inverted values so stale ones cannot match.
  task automatic cyc(input logic wr, logic [23:0] a);
    @(posedge sys_clk);
    tgt_bus <= '{1'h1, wr, a, a[15:0]};
    @(posedge sys_clk);
    tgt_bus <= '{1'h0, ~wr, ~a, ~a[15:0]};
  endtask
  // Back-to-back cycles whose address counts up from a and whose data counts up from zero.
  task automatic burst(input int n, logic [23:0] a);
    for (int k = 0; k < n; k++) begin
      @(posedge sys_clk);
      tgt_bus <= '{1'h1, k[0], a + 24'(k), 16'(k)};
    end
    @(posedge sys_clk);
    tgt_bus <= '{1'h0, 1'h0, ~a, 16'hFFFF};
  endtask
  task automatic run(input logic on);
    @(posedge sys_clk);
    prog_run <= on;
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the event sequencer, trigger and trace block.
// Assumes the target model drives the monitored bus and run level.
`timescale 1ns/1ps
`include "ees_params.svh"
module testbench;
  logic sys_clk;
  logic rst_b;
  ees_pkg::ees_bus_t tgt_bus;
  logic prog_run;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [3:0] external_probe_connector_two;
  logic break_req;
  logic [31:0] rv;
  int errors;
  int comparisons;
  localparam logic [23:0] TA = 24'hFFDEE0;
  localparam logic [23:0] A0 = 24'h0011A0;
  localparam logic [23:0] A1 = 24'h0011C4;
  localparam logic [23:0] A2 = 24'hFFEF8C;
  localparam logic [23:0] A3 = 24'hFFD404;
  ees_tgt_model tgt (
    .sys_clk(sys_clk),
    .tgt_bus(tgt_bus),
    .prog_run(prog_run)
  );
  ees_top DUT (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .tgt_bus(tgt_bus),
    .prog_run(prog_run),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .external_probe_connector_two(external_probe_connector_two),
    .break_req(break_req)
  );
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The wait is bounded so a dead slave ends the run instead of hanging.
  task automatic bus(input logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    address <= a;
    read <= ~w;
    write <= w;
    writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 50);
    rv = readdata;
    read <= 1'h0;
    write <= 1'h0;
    if (waitrequest !== 1'h0) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic rchk(input logic [7:0] a, logic [31:0] e, string nm);
    bus(1'h0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  task automatic pchk(input logic w, logic [23:0] a, logic [3:0] e);
    tgt.cyc(w, a);
    #1 chk("probe", {28'h0, e}, {28'h0, external_probe_connector_two});
  endtask
  task automatic scyc(input logic [23:0] a, logic [31:0] e);
    tgt.cyc(1'h0, a);
    rchk(`EES_OFS_STATUS, e, "status");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(`EES_OFS_STATUS, 32'h0, "status");
    rchk(`EES_OFS_TRIG_EN, 32'h0, "trig_en");
    rchk(8'h50, 32'h1, "pass0");
    rchk(8'h60, 32'h0, "unmapped");
  endtask
  task automatic t_trig();
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, 8'h20 + 8'(4 * i), {8'h00, TA + 24'(i)});
    end
    bus(1'h1, `EES_OFS_TRIG_EN, 32'hF);
    tgt.run(1'h1);
    for (int i = 0; i < 4; i++) begin
      pchk(i[0], TA + 24'(i), 4'(1 << i));
    end
    bus(1'h1, `EES_OFS_TRIG_EN, 32'hD);
    pchk(1'h0, TA + 24'h1, 4'h0);
    pchk(1'h1, TA + 24'h2, 4'h4);
    bus(1'h1, `EES_OFS_STATUS, 32'h1);
    rchk(`EES_OFS_TRIG_EN, 32'h0, "trig_en");
    rchk(8'h28, {8'h00, TA + 24'h2}, "trig_addr");
    tgt.run(1'h0);
  endtask
  // Point 1 is armed by point 0 and breaks; point 0 needs two passes.
  task automatic t_seq();
    bus(1'h1, 8'h40, {8'h00, A0});
    bus(1'h1, 8'h44, {8'h00, A1});
    bus(1'h1, 8'h50, 32'h2);
    bus(1'h1, 8'h30, 32'h1);
    bus(1'h1, 8'h34, 32'h403);
    tgt.run(1'h1);
    scyc(A1, 32'h80);
    scyc(A0, 32'h80);
    scyc(A0, 32'h81);
    scyc(A1, 32'h93);
    scyc(A0, 32'h93);
    chk("break", 32'h1, {31'h0, break_req});
    tgt.run(1'h0);
    bus(1'h0, `EES_OFS_STATUS, 32'h0);
    chk("status", 32'h0, rv & 32'hF);
    chk("break", 32'h0, {31'h0, break_req});
  endtask
  // Point 1 armed by non-occurrence; point 3 resets point 2.
  task automatic t_rst();
    bus(1'h1, 8'h48, {8'h00, A2});
    bus(1'h1, 8'h4C, {8'h00, A3});
    bus(1'h1, 8'h34, 32'h203);
    bus(1'h1, 8'h38, 32'h101);
    bus(1'h1, 8'h3C, 32'h1);
    tgt.run(1'h1);
    scyc(A1, 32'h82);
    scyc(A2, 32'h86);
    scyc(A3, 32'h8A);
    scyc(A2, 32'h8E);
    scyc(A3, 32'h8E);
    tgt.run(1'h0);
    rchk(`EES_OFS_TRACE_WP, 32'h5, "trace_wp");
    bus(1'h1, `EES_OFS_TRACE_IDX, 32'h0);
    rchk(`EES_OFS_TRACE_ADDR, {8'h00, A1}, "trace_addr");
    rchk(`EES_OFS_TRACE_DATA, 32'h11C4, "trace_data");
  endtask
  // A disabled point keeps its settings; a mid-run reset clears all but the trace store.
  task automatic t_mid();
    bus(1'h1, 8'h38, 32'h100);
    bus(1'h1, `EES_OFS_TRIG_EN, 32'hF);
    tgt.run(1'h1);
    scyc(A2, 32'h80);
    rchk(8'h38, 32'h100, "ev_cfg");
    pchk(1'h0, TA, 4'h1);
    @(posedge sys_clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'h1;
    rchk(`EES_OFS_STATUS, 32'h80, "status");
    rchk(`EES_OFS_TRIG_EN, 32'h0, "trig_en");
    rchk(8'h38, 32'h0, "ev_cfg");
    pchk(1'h0, TA, 4'h0);
    tgt.run(1'h0);
  endtask
  // Overfill the store so the two oldest records are overwritten.
  task automatic t_trace();
    tgt.run(1'h1);
    tgt.burst(`EES_TRACE_DEPTH + 2, A0);
    tgt.run(1'h0);
    rchk(`EES_OFS_TRACE_WP, 32'h8002, "trace_wp");
    bus(1'h1, `EES_OFS_TRACE_IDX, 32'h1);
    rchk(`EES_OFS_TRACE_ADDR, {8'h00, A0 + 24'h8001}, "trace_addr");
    rchk(`EES_OFS_TRACE_DATA, 32'h18001, "trace_data");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'h0;
    address = 8'h00;
    read = 1'h0;
    write = 1'h0;
    writedata = 32'h0;
    errors = 0;
    comparisons = 0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'h1;
    t_reset();
    t_trig();
    t_seq();
    t_rst();
    t_mid();
    t_trace();
    end_of_test();
  end
endmodule

// ### hdl/ees_params.svh
// Constants of the event sequencer, trigger and trace block.
// Assumes one 100 MHz clock and a target bus sampled on that clock.
`ifndef EES_PARAMS_SVH
`define EES_PARAMS_SVH
`define EES_NPT 4
`define EES_AW 24
`define EES_DW 16
`define EES_TRACE_DEPTH 32768
`define EES_TRACE_IW 15
`define EES_OFS_STATUS 8'h00
`define EES_OFS_TRIG_EN 8'h08
`define EES_OFS_DELAY 8'h0C
`define EES_OFS_TRACE_IDX 8'h10
`define EES_OFS_TRACE_ADDR 8'h14
`define EES_OFS_TRACE_DATA 8'h18
`define EES_OFS_TRACE_WP 8'h1C
`define EES_GRP_TRIG_ADDR 4'h2
`define EES_GRP_EV_CFG 4'h3
`define EES_GRP_EV_ADDR 4'h4
`define EES_GRP_EV_PASS 4'h5
`define EES_CTRL_CLEAR_ALL 0
`define EES_CFG_EN 0
`define EES_CFG_ARM_LSB 1
`define EES_CFG_RST_LSB 5
`define EES_CFG_NOOCC 9
`define EES_CFG_BRK 10
`define EES_CFG_W 11
`define EES_CFG_RST 11'h000
`define EES_PASS_RST 16'h0001
`define EES_DELAY_RST 16'h0000
`endif

// ### hdl/ees_pkg.sv
// Types shared by the event sequencer, trigger and trace block.
// Assumes the constants header is present in the include path.
`include "ees_params.svh"
package ees_pkg;
  typedef struct packed {
    logic valid;
    logic wr;
    logic [`EES_AW-1:0] addr;
    logic [`EES_DW-1:0] data;
  } ees_bus_t;
  typedef struct packed {
    logic wr;
    logic [`EES_AW-1:0] addr;
    logic [`EES_DW-1:0] data;
  } ees_trace_t;
endpackage

// ### hdl/ees_top.sv
// Event sequencer, probe trigger channels and trace store of the emulator.
// Assumes the target bus and run level are synchronous to sys_clk.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ees_params.svh"
module ees_top (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Target bus monitor and run state.
  input wire ees_pkg::ees_bus_t tgt_bus,
  input wire logic prog_run,
  // Avalon-MM register slave.
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Probe outputs and break request.
  output logic [3:0] external_probe_connector_two,
  output logic break_req
);

  ////////////////////////////////////////////////////////////////////////////
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_go;
  logic [5:0] idx;
  logic wr_ctrl;
  logic wr_trig_en;
  logic wr_delay;
  logic wr_tidx;
  logic wr_trig_addr;
  logic wr_ev_cfg;
  logic wr_ev_addr;
  logic wr_ev_pass;
  logic [3:0] tr_en_q;
  logic [`EES_AW-1:0] tr_addr_q [`EES_NPT];
  logic [3:0] trig_q;
  logic [`EES_CFG_W-1:0] ev_cfg_q [`EES_NPT];
  logic [`EES_AW-1:0] ev_addr_q [`EES_NPT];
  logic [15:0] ev_pass_q [`EES_NPT];
  logic [15:0] cnt_q [`EES_NPT];
  logic [3:0] sat_q;
  logic [3:0] set_p;
  logic [3:0] brk_m;
  logic [15:0] delay_q;
  logic [15:0] del_cnt_q;
  logic del_act_q;
  logic brk_q;
  logic run_q;
  logic start;
  logic [`EES_TRACE_IW-1:0] wp_q;
  logic [`EES_TRACE_IW-1:0] wr_idx;
  logic wrap_q;
  logic [`EES_TRACE_IW-1:0] tidx_q;
  ees_pkg::ees_trace_t mem [`EES_TRACE_DEPTH];
  ees_pkg::ees_trace_t trd;

  assign waitrequest = wait_q;
  assign readdata = rdata_q;
  assign external_probe_connector_two = trig_q;
  assign break_req = brk_q;
  assign idx = address[7:2];
  assign wr_go = write && !wait_q;
  assign start = prog_run && !run_q;

  assign wr_ctrl = wr_go && address == `EES_OFS_STATUS;
  assign wr_trig_en = wr_go && address == `EES_OFS_TRIG_EN;
  assign wr_delay = wr_go && address == `EES_OFS_DELAY;
  assign wr_tidx = wr_go && address == `EES_OFS_TRACE_IDX;
  assign wr_trig_addr = wr_go && idx[5:2] == `EES_GRP_TRIG_ADDR;
  assign wr_ev_cfg = wr_go && idx[5:2] == `EES_GRP_EV_CFG;
  assign wr_ev_addr = wr_go && idx[5:2] == `EES_GRP_EV_ADDR;
  assign wr_ev_pass = wr_go && idx[5:2] == `EES_GRP_EV_PASS;

  ////////////////////////////////////////////////////////////////////////////
  // Every access takes one wait cycle so read data can come from a flop.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(wait_q && (read || write));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (wait_q && read) begin
      rdata_q <= rdata_d;
    end
  end

  assign trd = mem[tidx_q];

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (address)
      `EES_OFS_STATUS: begin
        rdata_d[7:0] = {prog_run, del_act_q, wrap_q, brk_q, sat_q};
      end
      `EES_OFS_TRIG_EN: begin
        rdata_d[3:0] = tr_en_q;
      end
      `EES_OFS_DELAY: begin
        rdata_d[15:0] = delay_q;
      end
      `EES_OFS_TRACE_IDX: begin
        rdata_d[`EES_TRACE_IW-1:0] = tidx_q;
      end
      `EES_OFS_TRACE_ADDR: begin
        rdata_d[`EES_AW-1:0] = trd.addr;
      end
      `EES_OFS_TRACE_DATA: begin
        rdata_d[16:0] = {trd.wr, trd.data};
      end
      `EES_OFS_TRACE_WP: begin
        rdata_d[`EES_TRACE_IW:0] = {wrap_q, wp_q};
      end
      default: begin
        case (idx[5:2])
          `EES_GRP_TRIG_ADDR: begin
            rdata_d[`EES_AW-1:0] = tr_addr_q[idx[1:0]];
          end
          `EES_GRP_EV_CFG: begin
            rdata_d[`EES_CFG_W-1:0] = ev_cfg_q[idx[1:0]];
          end
          `EES_GRP_EV_ADDR: begin
            rdata_d[`EES_AW-1:0] = ev_addr_q[idx[1:0]];
          end
          `EES_GRP_EV_PASS: begin
            rdata_d[15:0] = ev_pass_q[idx[1:0]];
          end
          default: begin
            rdata_d = 32'h0000_0000;
          end
        endcase
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global control registers.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tr_en_q <= 4'h0;
    end else if (wr_ctrl && writedata[`EES_CTRL_CLEAR_ALL]) begin
      tr_en_q <= 4'h0;
    end else if (wr_trig_en) begin
      tr_en_q <= writedata[3:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_q <= `EES_DELAY_RST;
    end else if (wr_delay) begin
      delay_q <= writedata[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tidx_q <= '0;
    end else if (wr_tidx) begin
      tidx_q <= writedata[`EES_TRACE_IW-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 1'b0;
    end else begin
      run_q <= prog_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel trigger logic and per-point sequencer.
  for (genvar i = 0; i < `EES_NPT; i++) begin : g_pt
    logic [3:0] arm_m;
    logic [3:0] rst_m;
    logic [3:0] arm_src;
    logic armed;
    logic match;
    logic hit;
    logic reach;
    logic clr;
    logic sel;

    assign sel = idx[1:0] == 2'(i);

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        tr_addr_q[i] <= '0;
      end else if (wr_trig_addr && sel) begin
        tr_addr_q[i] <= writedata[`EES_AW-1:0];
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        ev_cfg_q[i] <= `EES_CFG_RST;
      end else if (wr_ev_cfg && sel) begin
        ev_cfg_q[i] <= writedata[`EES_CFG_W-1:0];
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        ev_addr_q[i] <= '0;
      end else if (wr_ev_addr && sel) begin
        ev_addr_q[i] <= writedata[`EES_AW-1:0];
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        ev_pass_q[i] <= `EES_PASS_RST;
      end else if (wr_ev_pass && sel) begin
        ev_pass_q[i] <= writedata[15:0];
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        trig_q[i] <= 1'b0;
      end else begin
        trig_q[i] <= tr_en_q[i] && prog_run && tgt_bus.valid &&
                     tgt_bus.addr == tr_addr_q[i];
      end
    end

    assign arm_m = ev_cfg_q[i][`EES_CFG_ARM_LSB +: 4];
    assign rst_m = ev_cfg_q[i][`EES_CFG_RST_LSB +: 4];
    assign brk_m[i] = ev_cfg_q[i][`EES_CFG_BRK];
    // One polarity bit per point serves all of its arm sources.
    assign arm_src = ev_cfg_q[i][`EES_CFG_NOOCC] ? ~sat_q : sat_q;
    assign armed = (arm_m == 4'h0) || |(arm_m & arm_src);
    assign match = prog_run && tgt_bus.valid && ev_cfg_q[i][`EES_CFG_EN] &&
                   tgt_bus.addr == ev_addr_q[i];
    assign hit = match && armed && !sat_q[i];
    // A pass count of zero fires on the first occurrence, like one.
    assign reach = ({1'b0, cnt_q[i]} + 17'h0_0001) >=
                   {1'b0, ev_pass_q[i]};
    assign set_p[i] = hit && reach;
    // Sources act on their set pulse, so a held state resets nothing.
    assign clr = |(rst_m & set_p);

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        sat_q[i] <= 1'b0;
      end else if (!prog_run || start) begin
        sat_q[i] <= 1'b0;
      end else if (clr) begin
        sat_q[i] <= 1'b0;
      end else if (hit && reach) begin
        sat_q[i] <= 1'b1;
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt_q[i] <= 16'h0000;
      end else if (!prog_run || start || clr) begin
        cnt_q[i] <= 16'h0000;
      end else if (hit && !reach) begin
        cnt_q[i] <= cnt_q[i] + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only one delay counter exists, so overlapping breaks share it.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      del_act_q <= 1'b0;
      del_cnt_q <= 16'h0000;
    end else if (!prog_run) begin
      del_act_q <= 1'b0;
      del_cnt_q <= 16'h0000;
    end else if (del_act_q) begin
      if (tgt_bus.valid) begin
        del_cnt_q <= del_cnt_q - 16'h0001;
        if (del_cnt_q == 16'h0001) begin
          del_act_q <= 1'b0;
        end
      end
    end else if (|(set_p & brk_m) && !brk_q) begin
      if (delay_q != 16'h0000) begin
        del_act_q <= 1'b1;
        del_cnt_q <= delay_q;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      brk_q <= 1'b0;
    end else if (!prog_run) begin
      brk_q <= 1'b0;
    end else if (del_act_q && tgt_bus.valid && del_cnt_q == 16'h0001) begin
      brk_q <= 1'b1;
    end else if (!del_act_q && |(set_p & brk_m) && delay_q == 16'h0000) begin
      brk_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trace store, pointer restarted at each run; records past it are left from earlier runs.
  assign wr_idx = start ? '0 : wp_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= '0;
    end else if (start) begin
      wp_q <= {{(`EES_TRACE_IW-1){1'b0}}, tgt_bus.valid};
    end else if (prog_run && tgt_bus.valid) begin
      wp_q <= wp_q + 15'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrap_q <= 1'b0;
    end else if (start) begin
      wrap_q <= 1'b0;
    end else if (prog_run && tgt_bus.valid && &wp_q) begin
      wrap_q <= 1'b1;
    end
  end

  // The store has no reset; its contents mean nothing before a run.
  always_ff @(posedge sys_clk) begin
    if (prog_run && tgt_bus.valid) begin
      mem[wr_idx] <= '{wr: tgt_bus.wr, addr: tgt_bus.addr,
                       data: tgt_bus.data};
    end
  end

endmodule
